// [rtl/asr_ctrl.sv]
// Host controller for an asynchronous byte-wide static RAM.
// Assumes a request port on the same clock and raw memory pins outside.
// Function
// - Address valid before chip select falls
// - Address changes only with strobes high
// - Never drive data while memory drives
// - Each cycle lasts at least 12 ns
// - Address valid 8 ns before write end
// - Select low 8 ns before write end
// - Write strobe overlap at least 8 ns
// - Address setup of zero before write start
// - Address held zero after write end
// - Data setup 6 ns, hold 0 ns
// - Deselect before supply drop, wait 5 ms
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl #(
    parameter int ADDR_W       = asr_pkg::ADDR_W,
    parameter int DATA_W       = asr_pkg::DATA_W,
    parameter int RECOVERY_CYC = asr_pkg::RECOVERY_CYC
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // Request port
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    output var  logic              req_ready,
    output var  logic              rsp_valid,
    output var  logic [DATA_W-1:0] rsp_rdata,
    // Supply control
    input  wire logic              power_low,
    // Memory pins
    output var  logic [ADDR_W-1:0] word_address_lines,
    output var  logic              chip_select_n,
    output var  logic              output_enable_n,
    output var  logic              write_enable_n,
    input  wire logic [DATA_W-1:0] shared_data_lines_in,
    output var  logic [DATA_W-1:0] shared_data_lines_out,
    output var  logic              shared_data_lines_oe
);
    asr_timer_if tif ();                   // Phase timer link
    asr_pkg::asr_state_t state_r;          // Current state
    asr_pkg::asr_state_t state_nxt;        // Next state
    logic [DATA_W-1:0] din_s1_r;           // Data pin sync stage 1
    logic [DATA_W-1:0] din_s2_r;           // Data pin sync stage 2
    logic [DATA_W-1:0] din_s3_r;           // Data pin sync stage 3
    logic              pl_s1_r;            // Power flag sync stages
    logic              pl_s2_r;
    logic              pl_s3_r;
    logic              pl_r;               // Settled power flag
    logic              take;               // Request accepted
    logic              din_stable;         // Stages 2 and 3 agree
    logic              pl_nxt;             // Power flag after this edge

    asr_timer u_timer (
        .clock   (clock),
        .reset_n (reset_n),
        .tif     (tif)
    );

    // Input synchronisers for pins from outside the clock domain
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
            din_s3_r <= 8'h00;
            pl_s1_r  <= 1'b1;
            pl_s2_r  <= 1'b1;
            pl_s3_r  <= 1'b1;
        end else begin
            din_s1_r <= shared_data_lines_in;
            din_s2_r <= din_s1_r;
            din_s3_r <= din_s2_r;
            pl_s1_r  <= power_low;
            pl_s2_r  <= pl_s1_r;
            pl_s3_r  <= pl_s2_r;
        end
    end
    // Power flag changes once two stages agree
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pl_r <= 1'b1;
        end else if (pl_s2_r == pl_s3_r) begin
            pl_r <= pl_s3_r;
        end
    end

    assign din_stable = (din_s2_r == din_s3_r);
    assign take       = req_ready && req_valid;
    assign pl_nxt     = (pl_s2_r == pl_s3_r) ? pl_s3_r : pl_r;

    // Next state and timer loads
    always_comb begin
        state_nxt = state_r;
        tif.load  = 1'b0;
        tif.count = 21'h000000;
        unique case (state_r)
            asr_pkg::ASR_RECOVER: begin
                if (pl_r) begin
                    tif.load  = 1'b1;
                    tif.count = 21'(RECOVERY_CYC);
                end else if (tif.done) begin
                    state_nxt = asr_pkg::ASR_IDLE;
                end
            end
            asr_pkg::ASR_IDLE: begin
                if (pl_r) begin
                    state_nxt = asr_pkg::ASR_SLEEP;
                end else if (take) begin
                    tif.load  = 1'b1;
                    state_nxt = req_write ? asr_pkg::ASR_WRITE
                                          : asr_pkg::ASR_READ;
                    tif.count = req_write ? 21'(asr_pkg::WPULSE_CYC)
                                          : 21'(asr_pkg::READ_CYC);
                end
            end
            asr_pkg::ASR_READ: begin
                if (tif.done && din_stable) begin
                    tif.load  = 1'b1;
                    tif.count = 21'(asr_pkg::FLOAT_CYC);
                    state_nxt = asr_pkg::ASR_TURN;
                end
            end
            asr_pkg::ASR_WRITE: begin
                if (tif.done) begin
                    tif.load  = 1'b1;
                    tif.count = 21'(asr_pkg::CYCLE_CYC - asr_pkg::WPULSE_CYC);
                    state_nxt = asr_pkg::ASR_WHOLD;
                end
            end
            asr_pkg::ASR_WHOLD: begin
                if (tif.done) begin
                    state_nxt = asr_pkg::ASR_IDLE;
                end
            end
            asr_pkg::ASR_TURN: begin
                if (tif.done) begin
                    state_nxt = asr_pkg::ASR_IDLE;
                end
            end
            asr_pkg::ASR_SLEEP: begin
                if (!pl_r) begin
                    state_nxt = asr_pkg::ASR_RECOVER;
                    tif.load  = 1'b1;
                    tif.count = 21'(RECOVERY_CYC);
                end
            end
            default: begin
                state_nxt = asr_pkg::ASR_RECOVER;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= asr_pkg::ASR_RECOVER;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Address and write data latch on acceptance only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            word_address_lines    <= '0;
            shared_data_lines_out <= 8'h00;
        end else if (take) begin
            word_address_lines    <= req_addr;
            shared_data_lines_out <= req_wdata;
        end
    end

    // Strobes: select and one of enable/write low per access
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            chip_select_n        <= 1'b1;
            output_enable_n      <= 1'b1;
            write_enable_n       <= 1'b1;
            shared_data_lines_oe <= 1'b0;
        end else begin
            chip_select_n   <= !(state_nxt == asr_pkg::ASR_READ ||
                                 state_nxt == asr_pkg::ASR_WRITE);
            output_enable_n <= (state_nxt != asr_pkg::ASR_READ);
            write_enable_n  <= (state_nxt != asr_pkg::ASR_WRITE);
            shared_data_lines_oe <= (state_nxt == asr_pkg::ASR_WRITE ||
                                     state_nxt == asr_pkg::ASR_WHOLD);
        end
    end

    // Ready and read answer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
        end else begin
            // Ready drops on the same edge as the power flag rises, so no taken
            // request is ever dropped by the move to sleep
            req_ready <= (state_nxt == asr_pkg::ASR_IDLE) && !take &&
                         !pl_nxt;
            rsp_valid <= (state_r == asr_pkg::ASR_READ) &&
                         (state_nxt == asr_pkg::ASR_TURN);
            if ((state_r == asr_pkg::ASR_READ) &&
                (state_nxt == asr_pkg::ASR_TURN)) begin
                rsp_rdata <= din_s3_r;
            end
        end
    end

    // Write strobe low for its whole pulse
    sequence wr_pulse_s;
        !write_enable_n [*2];
    endsequence
    // Output enable low for a whole read cycle
    sequence rd_cycle_s;
        !output_enable_n [*3];
    endsequence
    // Write strobe lasts its full pulse width
    write_pulse_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        $fell(write_enable_n) |-> wr_pulse_s)
        else $error("write strobe too short");
    // Chip select low throughout a write pulse
    write_select_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        !write_enable_n |-> !chip_select_n)
        else $error("write without chip select");
    // Address steady while write strobe low
    addr_steady_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        !write_enable_n && $past(!write_enable_n) |->
        $stable(word_address_lines))
        else $error("address moved during write");
    // Address stable while selected
    addr_select_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        !chip_select_n && $past(!chip_select_n) |->
        $stable(word_address_lines))
        else $error("address moved while selected");
    // No host drive while memory drives
    no_contend_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        !output_enable_n |-> !shared_data_lines_oe)
        else $error("bus contention");
    // Write data stable over strobe
    wdata_stable_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        !write_enable_n |=> $stable(shared_data_lines_out))
        else $error("write data changed");
    // Read held at least three cycles
    read_len_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        $fell(output_enable_n) |-> rd_cycle_s)
        else $error("read cycle too short");
    // Deselected while supply is low
    retention_a : assert property (
        @(posedge clock) disable iff (!reset_n)
        pl_r |=> chip_select_n [*2])
        else $error("selected in low supply");
endmodule : asr_ctrl
`default_nettype wire

// [rtl/asr_pkg.sv]
// Constants for the byte-wide asynchronous static RAM host controller.
// Assumes a single 250 MHz clock; cycle, access, write pulse and float times become cycle counts.
package asr_pkg;
    // Clock period in picoseconds
    localparam int CLK_PS          = 4000;
    // Array geometry
    localparam int ADDR_W          = 19;
    localparam int DATA_W          = 8;
    // Pin timings in nanoseconds, as printed
    localparam int CYCLE_NS        = 12;
    localparam int ACCESS_NS       = 12;
    localparam int OE_ACCESS_NS    = 6;
    localparam int WRITE_PULSE_NS  = 8;
    localparam int DATA_SETUP_NS   = 6;
    localparam int DATA_HOLD_NS    = 0;
    localparam int FLOAT_NS        = 6;
    // Recovery wait after supply returns, in milliseconds
    localparam int RECOVERY_MS     = 5;
    // Least times rounded up to whole cycles, never below one
    function automatic int min_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction : min_cyc
    // Cycles from a pin sample to stage three of the data synchroniser
    localparam int SYNC_CYC   = 2;
    // Read timer: access time, one cycle of margin, then sync latency,
    // so stage three holds a pin sample taken past the access time
    localparam int READ_CYC   = min_cyc(ACCESS_NS) + 1 + SYNC_CYC;
    // Write strobe low time, covers pulse width and data setup
    localparam int WPULSE_CYC = min_cyc(WRITE_PULSE_NS);
    // Whole cycle time, for both reads and writes
    localparam int CYCLE_CYC  = min_cyc(CYCLE_NS);
    // Turnaround after a read before the host may drive data
    localparam int FLOAT_CYC  = min_cyc(FLOAT_NS);
    // Recovery wait in cycles (5 ms at 250 MHz)
    localparam int RECOVERY_CYC = RECOVERY_MS * 250000;
    // Controller states
    typedef enum logic [2:0] {
        ASR_RECOVER = 3'b000,
        ASR_IDLE    = 3'b001,
        ASR_READ    = 3'b010,
        ASR_WRITE   = 3'b011,
        ASR_WHOLD   = 3'b100,
        ASR_TURN    = 3'b101,
        ASR_SLEEP   = 3'b110
    } asr_state_t;
endpackage : asr_pkg

// [rtl/asr_timer_if.sv]
// Carrier between the controller and its cycle timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface asr_timer_if;
    logic        load;     // Start a new count
    logic [20:0] count;    // Cycles to run
    logic        done;     // Count has expired
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : asr_timer_if
`default_nettype wire

// [rtl/asr_timer.sv]
// Down counter that times each phase of a pin sequence.
// Assumes load pulses only come from the controller on the same clock.
`timescale 1ns/1ns
`default_nettype none
module asr_timer (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset_n,
    // Controller side
    asr_timer_if.tmr  tif
);
    logic [20:0] cnt_r;   // Remaining cycles
    // Count down to zero after each load
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r <= 21'h000000;
        end else if (tif.load) begin
            cnt_r <= tif.count;
        end else if (cnt_r != 21'h000000) begin
            cnt_r <= cnt_r - 21'h000001;
        end
    end
    // Expired once the count reaches zero; kept free of load so the
    // controller's load decision never loops back through done
    assign tif.done = (cnt_r == 21'h000000);
endmodule : asr_timer
`default_nettype wire

// [tb/asr_sram_model.sv]
// Far-side model of the byte-wide static RAM.
// Assumes the bench merges mem_q with the host's own data drive.
`timescale 1ns/1ns
`default_nettype none
module asr_sram_model (
    // Pins from the host
    input  wire logic [18:0] word_address_lines,
    input  wire logic        chip_select_n,
    input  wire logic        output_enable_n,
    input  wire logic        write_enable_n,
    input  wire logic [7:0]  host_q,
    // Late answer when set
    input  wire logic        slow,
    // Drive toward the host
    output var  logic [7:0]  mem_q,
    output var  logic        mem_drive
);
    logic [7:0] cells [logic [18:0]]; // Sparse 512K by 8 array
    logic       armed = 1'b0;         // Write under way
    logic [7:0] rd;                   // Byte being read
    wire rdg = !chip_select_n && !output_enable_n && write_enable_n;
    wire wrg = !chip_select_n && !write_enable_n;
    initial mem_q = 8'h5A;
    initial mem_drive = 1'b0;
    // Byte lands when the first strobe rises
    always @(wrg) begin
        if (wrg === 1'b1)
            armed = 1'b1;
        else if (armed) begin
            cells[word_address_lines] = host_q;
            armed = 1'b0;
        end
    end
    // Drive only in read mode: stale byte first, then the cell
    always @(rdg or word_address_lines) begin
        rd = cells.exists(word_address_lines) ?
             cells[word_address_lines] : 8'h00;
        if (rdg === 1'b1) begin
            mem_drive <= #3 1'b1;
            mem_q <= #3 ~mem_q;
            mem_q <= #(slow ? 12 : 4) rd;
        end else begin
            mem_drive <= #2 1'b0;
            mem_q <= #2 ~mem_q;            // Released lines drift
        end
    end
endmodule : asr_sram_model
`default_nettype wire

// [tb/asr_ctrl_tb.sv]
// Self-checking bench for the static RAM host controller.
// Assumes the memory model beside it and a 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none
module asr_ctrl_tb;
    localparam int REC = 20;               // Short recovery wait
    logic        clock = 1'b0;             // 4 ns clock
    logic        reset_n = 1'b0;           // Held low at start
    logic        req_valid = 1'b0;         // Request strobe
    logic        req_write = 1'b0;         // Write when set
    logic [18:0] req_addr = 19'h00000;     // Request address
    logic [7:0]  req_wdata = 8'h00;        // Write byte
    logic        power_low = 1'b0;         // Supply going low
    logic        slow = 1'b0;              // Late memory answers
    logic        req_ready, rsp_valid, cs_n, oe_n, we_n, host_oe, mem_drive;
    logic [7:0]  rsp_rdata, host_q, mem_q, dq_in, prev_q;
    logic [18:0] addr_q, prev_addr, ra;    // Pin and draw addresses
    logic [7:0]  ref_mem [logic [18:0]];   // Expected contents
    logic [31:0] rnd;                      // Random draw
    logic        prev_wr = 1'b0;           // Write overlap last cycle
    int fails = 0, num_checks = 0, cyc = 0, wlow = 0, clow = 0;
    int seed = 15, n = 0;
    // Data wire as both parties see it
    assign dq_in = host_oe ? host_q : mem_q;
    asr_ctrl #(.RECOVERY_CYC(REC)) uut (
        .clock(clock), .reset_n(reset_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .power_low(power_low), .word_address_lines(addr_q),
        .chip_select_n(cs_n), .output_enable_n(oe_n), .write_enable_n(we_n),
        .shared_data_lines_in(dq_in), .shared_data_lines_out(host_q),
        .shared_data_lines_oe(host_oe));
    asr_sram_model mdl (
        .word_address_lines(addr_q), .chip_select_n(cs_n),
        .output_enable_n(oe_n), .write_enable_n(we_n), .host_q(host_q),
        .slow(slow), .mem_q(mem_q), .mem_drive(mem_drive));
    // Free-running clock
    initial forever #2 clock = ~clock;
    // Compare and tally
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
        end
    endtask : check
    // Print the tallies and the verdict, then stop
    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    // Expected byte at an address
    function automatic logic [7:0] exp_byte(input logic [18:0] a);
        return ref_mem.exists(a) ? ref_mem[a] : 8'h00;
    endfunction : exp_byte
    // Hold one request until it is taken
    task automatic do_req(input logic w, input logic [18:0] a,
                          input logic [7:0] d);
        n = 0;
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(posedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 200);
        req_valid <= 1'b0;
        check(32'(n < 200), 32'h1);
    endtask : do_req
    // Write one byte and look at the pins it sets
    task automatic do_write(input logic [18:0] a, input logic [7:0] d);
        do_req(1'b1, a, d);
        ref_mem[a] = d;
        @(negedge clock);
        check(32'({cs_n, oe_n, we_n, host_oe}), 32'h5);
        check(32'(addr_q), 32'(a));
        check(32'(host_q), 32'(d));
    endtask : do_write
    // Read one byte and compare with the last write there
    task automatic do_read(input logic [18:0] a);
        int k;
        k = 0;
        do_req(1'b0, a, 8'h00);
        @(negedge clock);
        check(32'({cs_n, oe_n, we_n, host_oe}), 32'h2);
        do begin
            @(posedge clock);
            k++;
        end while (rsp_valid !== 1'b1 && k < 40);
        check(32'(rsp_valid), 32'h1);
        check(32'(rsp_rdata), 32'(exp_byte(a)));
        check(32'(k >= asr_pkg::CYCLE_CYC), 32'h1);
    endtask : do_read
    // Pin watch at mid-cycle, where outputs have settled
    always @(negedge clock) begin
        if (reset_n === 1'b1) begin
            if (host_oe && mem_drive)
                check(32'h1, 32'h0);
            if (prev_wr && !cs_n && !we_n && addr_q !== prev_addr)
                check(32'h1, 32'h0);
            if (prev_wr && !we_n && host_q !== prev_q)
                check(32'h1, 32'h0);
            if (we_n && wlow > 0) begin
                check(32'(wlow >= asr_pkg::WPULSE_CYC), 32'h1);
                check(32'(host_oe), 32'h1);
            end
            if (cs_n && clow > 0)
                check(32'(clow >= asr_pkg::CYCLE_CYC), 32'h1);
        end
        wlow = we_n ? 0 : wlow + 1;
        clow = cs_n ? 0 : clow + 1;
        prev_wr = !cs_n && !we_n;
        prev_addr = addr_q;
        prev_q = host_q;
    end
    // Cut a hang short
    always @(posedge clock) begin
        cyc++;
        if (cyc == 5000) begin
            fails++;
            complete_run();
        end
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        // First request waits out the recovery time
        do_write(19'h00000, 8'hFF);
        check(32'(n >= REC), 32'h1);
        // Array ends, back to back, then an overwrite
        do_write(19'h7FFFF, 8'h00);
        do_read(19'h00000);
        do_read(19'h7FFFF);
        do_write(19'h7FFFF, 8'hA5);
        do_write(19'h7FFFF, 8'h5A);
        do_read(19'h7FFFF);
        // Random traffic on hot addresses 0 to 7 and odd addresses across the array
        repeat (40) begin
            rnd = $random(seed);
            slow <= rnd[23];
            ra = rnd[4] ? rnd[22:4] : {16'h0000, rnd[2:0]};
            if (rnd[30])
                do_write(ra, rnd[31:24]);
            else
                do_read(ra);
        end
        // Supply drop: deselected, refused, then a fresh wait
        power_low <= 1'b1;
        repeat (5) @(posedge clock);
        repeat (10) begin
            @(negedge clock);
            check(32'({cs_n, req_ready}), 32'h2);
        end
        power_low <= 1'b0;
        do_write(19'h00005, 8'h3C);
        check(32'(n >= REC), 32'h1);
        do_read(19'h00005);
        complete_run();
    end
endmodule : asr_ctrl_tb
`default_nettype wire
